//--- mcc_pkg.sv
/*
  Constants shared by the measurement command block: register offsets, command bit
  positions, reset values and timing counts.
  Assumes a 100 MHz core clock; every cycle count below is derived from that rate.
*/
`default_nettype none

package mcc_pkg;

  // ************************************************
  // Clock and register map
  // ************************************************
  localparam int unsigned CLK_MHZ = 100;
  localparam logic [26:0] CLK_HZ = 27'h5f5e100;
  localparam logic [7:0] RATE_ADDR = 8'h1a;
  localparam logic [7:0] CTRL0_ADDR = 8'h1b;
  localparam logic [7:0] NO_ADDR = 8'hff;
  localparam logic [7:0] RATE_RESET = 8'h00;
  localparam logic [7:0] CTRL0_RESET = 8'h00;
  localparam logic [7:0] SETXTIME_DEF = 8'h8f;

  // ************************************************
  // Command register fields
  // ************************************************
  localparam int unsigned BIT_FIELD = 0;
  localparam int unsigned BIT_TEMP = 1;
  localparam int unsigned BIT_MOTION = 2;
  localparam int unsigned BIT_SET = 3;
  localparam int unsigned BIT_RST = 4;
  localparam int unsigned BIT_AUTO_MAG = 5;
  localparam int unsigned BIT_SELFTEST = 6;
  localparam int unsigned BIT_CALC = 7;

  // ************************************************
  // Rates and timing
  // ************************************************
  localparam logic [7:0] RATE_MAX_CODE = 8'hff;
  localparam logic [1:0] FAST_FILTER_SEL = 2'h3;
  localparam logic [9:0] FAST_RATE_HZ = 10'h3e8;
  localparam int unsigned DIV_STEPS = 27;
  localparam int unsigned SR_PULSE_NS = 375;
  localparam int unsigned SR_PULSE_CYC = (SR_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned MEAS_BW0_US = 6600;
  localparam int unsigned MEAS_BW1_US = 3500;
  localparam int unsigned MEAS_BW2_US = 2000;
  localparam int unsigned MEAS_BW3_US = 1200;
  localparam int unsigned TEMP_MEAS_US = 1000;
  localparam int unsigned SELFTEST_US = 10000;
  localparam int unsigned MEAS_BW0_CYC = MEAS_BW0_US * CLK_MHZ;
  localparam int unsigned MEAS_BW1_CYC = MEAS_BW1_US * CLK_MHZ;
  localparam int unsigned MEAS_BW2_CYC = MEAS_BW2_US * CLK_MHZ;
  localparam int unsigned MEAS_BW3_CYC = MEAS_BW3_US * CLK_MHZ;
  localparam int unsigned TEMP_MEAS_CYC = TEMP_MEAS_US * CLK_MHZ;
  localparam int unsigned SELFTEST_CYC = SELFTEST_US * CLK_MHZ;
  localparam int unsigned PRD_SET_N [8] = '{1, 25, 75, 100, 250, 500, 1000, 2000};

  typedef enum logic [2:0] {ST_IDLE, ST_CALC, ST_SET, ST_RST, ST_MEAS, ST_TEMP, ST_TEST}
    mcc_state_t;

endpackage : mcc_pkg

`default_nettype wire

//--- mcc_wr_if.sv
/*
  Carrier for register writes leaving the link receiver.
  Assumes the receiver holds addr and data steady while the toggle is being synchronised.
*/
`timescale 1ns/1ps
`default_nettype none

interface mcc_wr_if;
  logic tgl;
  logic [7:0] addr;
  logic [7:0] data;

  modport rx (output tgl, output addr, output data);
  modport core (input tgl, input addr, input data);
endinterface : mcc_wr_if

`default_nettype wire

//--- mcc_link_rx.sv
/*
  Link-side byte receiver on the link clock: first byte of a frame is a register
  offset (or the defining byte of a common command), later bytes are data.
  Assumes the link clock runs only inside a frame and frame is low between frames.
*/
`timescale 1ns/1ps
`default_nettype none

module mcc_link_rx
  import mcc_pkg::*;
(
  input wire logic link_clk,
  input wire logic resetn,
  input wire logic link_frame,
  input wire logic link_ccc,
  input wire logic link_sda_i,
  output logic link_sda_o,
  output logic link_sda_oe_n,
  mcc_wr_if.rx wr
);

  // ************************************************
  // Bit and byte counting
  // ************************************************
  // The frame itself ends the count, so nothing relies on an edge after the frame.
  logic fr_rst_n;
  logic [3:0] bit_cnt_r;
  logic [6:0] shift_r;
  logic first_done_r;
  logic [7:0] addr_r;
  logic [7:0] byte_in;
  logic byte_end;

  assign fr_rst_n = resetn & link_frame;
  assign byte_in = {shift_r, link_sda_i};
  assign byte_end = (bit_cnt_r == 4'h7);
  assign link_sda_o = 1'b0;
  assign link_sda_oe_n = (bit_cnt_r != 4'h8);

  always_ff @(posedge link_clk or negedge fr_rst_n)
  begin
    if (!fr_rst_n)
    begin
      bit_cnt_r <= 4'h0;
      shift_r <= 7'h00;
    end
    else
    begin
      bit_cnt_r <= (bit_cnt_r == 4'h8) ? 4'h0 : bit_cnt_r + 4'h1;
      if (bit_cnt_r != 4'h8)
      begin
        shift_r <= byte_in[6:0];
      end
    end
  end

  always_ff @(posedge link_clk or negedge fr_rst_n)
  begin
    if (!fr_rst_n)
    begin
      first_done_r <= 1'b0;
      addr_r <= 8'h00;
    end
    else if (byte_end)
    begin
      first_done_r <= 1'b1;
      if (!first_done_r)
      begin
        addr_r <= byte_in;
      end
      else if (!link_ccc)
      begin
        addr_r <= addr_r + 8'h01;
      end
    end
  end

  // ************************************************
  // Publishing a write to the core domain
  // ************************************************
  // Only the frame reset clears the counters; the toggle survives between frames.
  always_ff @(posedge link_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wr.tgl <= 1'b0;
      wr.addr <= 8'h00;
      wr.data <= 8'h00;
    end
    else if (link_frame && byte_end && first_done_r)
    begin
      wr.tgl <= ~wr.tgl;
      wr.data <= byte_in;
      if (link_ccc)
      begin
        wr.addr <= (addr_r == SETXTIME_DEF) ? RATE_ADDR : NO_ADDR;
      end
      else
      begin
        wr.addr <= addr_r;
      end
    end
  end

  sequence ccc_rate_byte;
    link_frame && byte_end && first_done_r && link_ccc && (addr_r == SETXTIME_DEF);
  endsequence

  ccc_rate_a: assert property (@(posedge link_clk) disable iff (!fr_rst_n)
    ccc_rate_byte |=> (wr.addr == RATE_ADDR) && (wr.data == $past(byte_in)))
    else $error("Rate byte of the common command was not passed on as a rate write.");

  ack_slot_a: assert property (@(posedge link_clk) disable iff (!fr_rst_n)
    byte_end |=> !link_sda_oe_n ##1 (link_sda_oe_n && bit_cnt_r == 4'h0))
    else $error("Acknowledge slot was not driven for exactly one bit.");

endmodule : mcc_link_rx

`default_nettype wire

//--- mcc_top.sv
/*
  Measurement command and rate control: stores the sample-rate code and the command
  register, runs measurements, coil pulses, self-test and the sample period calculation.
  Assumes the analog path, status registers and other control registers sit outside
  and present their settings as plain same-clock inputs.
*/
`timescale 1ns/1ps
`default_nettype none

module mcc_top
  import mcc_pkg::*;
#(
  parameter int unsigned MEAS_CYC_BW0 = mcc_pkg::MEAS_BW0_CYC,
  parameter int unsigned MEAS_CYC_BW1 = mcc_pkg::MEAS_BW1_CYC,
  parameter int unsigned MEAS_CYC_BW2 = mcc_pkg::MEAS_BW2_CYC,
  parameter int unsigned MEAS_CYC_BW3 = mcc_pkg::MEAS_BW3_CYC,
  parameter int unsigned TEMP_CYC = mcc_pkg::TEMP_MEAS_CYC,
  parameter int unsigned TEST_CYC = mcc_pkg::SELFTEST_CYC
)
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic link_clk,
  input wire logic link_frame,
  input wire logic link_ccc,
  input wire logic link_sda_i,
  output logic link_sda_o,
  output logic link_sda_oe_n,
  input wire logic cont_run_enable,
  input wire logic high_power_sel,
  input wire logic [1:0] filter_length_sel,
  input wire logic periodic_set_enable,
  input wire logic [2:0] periodic_set_sel,
  input wire logic mag_data_read,
  output logic set_coil_drive,
  output logic reset_coil_drive,
  output logic field_measuring,
  output logic temp_measuring,
  output logic selftest_running,
  output logic field_result_ready,
  output logic continuous_active,
  output logic [7:0] sample_rate_code,
  output logic [7:0] command_bits,
  output logic [26:0] sample_period
);
  import mcc_pkg::*;

  localparam int unsigned TMR_W = 24;

  // ************************************************
  // Link receiver and write crossing
  // ************************************************
  mcc_wr_if wr_bus ();

  mcc_link_rx u_rx (
    .link_clk(link_clk),
    .resetn(resetn),
    .link_frame(link_frame),
    .link_ccc(link_ccc),
    .link_sda_i(link_sda_i),
    .link_sda_o(link_sda_o),
    .link_sda_oe_n(link_sda_oe_n),
    .wr(wr_bus.rx)
  );

  // The toggle is resynchronised; addr and data stay put for a whole byte time,
  // far longer than the two-stage delay, so they are read without their own sync.
  logic tgl_s1_r;
  logic tgl_s2_r;
  logic tgl_s3_r;
  logic wr_evt;
  logic wr_rate;
  logic wr_ctrl;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      tgl_s1_r <= 1'b0;
      tgl_s2_r <= 1'b0;
      tgl_s3_r <= 1'b0;
    end
    else if (ce)
    begin
      tgl_s1_r <= wr_bus.tgl;
      tgl_s2_r <= tgl_s1_r;
      tgl_s3_r <= tgl_s2_r;
    end
  end

  assign wr_evt = ce && (tgl_s2_r != tgl_s3_r);
  assign wr_rate = wr_evt && (wr_bus.addr == RATE_ADDR);
  assign wr_ctrl = wr_evt && (wr_bus.addr == CTRL0_ADDR);

  // ************************************************
  // Registers
  // ************************************************
  logic [7:0] rate_r;
  logic [7:0] cmd_r;
  logic [7:0] cmd_set;
  logic [7:0] cmd_clr;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rate_r <= RATE_RESET;
    end
    else if (wr_rate)
    begin
      rate_r <= wr_bus.data;
    end
  end

  always_comb
  begin
    cmd_set = wr_ctrl ? wr_bus.data : 8'h00;
    cmd_set[BIT_MOTION] = 1'b0;
    cmd_set[BIT_AUTO_MAG] = 1'b0;
  end

  // A command bit written in the same cycle its operation ends stays set.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cmd_r <= CTRL0_RESET;
    end
    else if (ce)
    begin
      cmd_r <= (cmd_r & ~cmd_clr) | cmd_set;
      if (wr_ctrl)
      begin
        cmd_r[BIT_AUTO_MAG] <= wr_bus.data[BIT_AUTO_MAG];
      end
    end
  end

  assign sample_rate_code = rate_r;
  assign command_bits = cmd_r;

  // ************************************************
  // Operation sequencer
  // ************************************************
  mcc_state_t state_r;
  logic [TMR_W-1:0] timer_r;
  logic [TMR_W-1:0] meas_load;
  logic [4:0] calc_cnt_r;
  logic next_meas_r;
  logic meas_manual_r;
  logic op_end;
  logic meas_done;
  logic take_tick;
  logic tick_pend_r;
  logic set_due;
  logic auto_mag;
  logic fast_rate;
  logic [9:0] div_r;
  logic [26:0] dvd_r;
  logic [10:0] rem_r;
  logic [10:0] trial;
  logic [26:0] quo_r;
  logic [26:0] quo_nxt;
  logic [10:0] smp_cnt_r;
  logic period_valid_r;

  assign auto_mag = cmd_r[BIT_AUTO_MAG];
  assign fast_rate = (rate_r == RATE_MAX_CODE) && high_power_sel
    && (filter_length_sel == FAST_FILTER_SEL);
  assign set_due = !periodic_set_enable || (smp_cnt_r == 11'h000);

  always_comb
  begin
    unique case (filter_length_sel)
      2'h0: meas_load = TMR_W'(MEAS_CYC_BW0 - 1);
      2'h1: meas_load = TMR_W'(MEAS_CYC_BW1 - 1);
      2'h2: meas_load = TMR_W'(MEAS_CYC_BW2 - 1);
      2'h3: meas_load = TMR_W'(MEAS_CYC_BW3 - 1);
    endcase
  end

  always_comb
  begin
    op_end = (timer_r == '0);
    cmd_clr = 8'h00;
    meas_done = 1'b0;
    take_tick = (state_r == ST_IDLE) && tick_pend_r && !cmd_r[BIT_CALC] && !cmd_r[BIT_SET]
      && !cmd_r[BIT_RST] && !cmd_r[BIT_SELFTEST];
    unique case (state_r)
      ST_IDLE: cmd_clr = 8'h00;
      ST_CALC: cmd_clr[BIT_CALC] = (calc_cnt_r == 5'h00);
      ST_SET: cmd_clr[BIT_SET] = op_end && !next_meas_r;
      ST_RST: cmd_clr[BIT_RST] = op_end;
      ST_MEAS:
      begin
        meas_done = op_end;
        cmd_clr[BIT_FIELD] = op_end && meas_manual_r;
      end
      ST_TEMP: cmd_clr[BIT_TEMP] = op_end;
      ST_TEST: cmd_clr[BIT_SELFTEST] = op_end;
    endcase
    if (!ce)
    begin
      cmd_clr = 8'h00;
      meas_done = 1'b0;
      take_tick = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= ST_IDLE;
      timer_r <= '0;
      calc_cnt_r <= 5'h00;
      next_meas_r <= 1'b0;
      meas_manual_r <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state_r)
        ST_IDLE:
        begin
          if (cmd_r[BIT_CALC])
          begin
            state_r <= ST_CALC;
            calc_cnt_r <= 5'(DIV_STEPS - 1);
          end
          else if (cmd_r[BIT_SET])
          begin
            state_r <= ST_SET;
            timer_r <= TMR_W'(SR_PULSE_CYC - 1);
            next_meas_r <= 1'b0;
          end
          else if (cmd_r[BIT_RST])
          begin
            state_r <= ST_RST;
            timer_r <= TMR_W'(SR_PULSE_CYC - 1);
          end
          else if (cmd_r[BIT_SELFTEST])
          begin
            state_r <= ST_TEST;
            timer_r <= TMR_W'(TEST_CYC - 1);
          end
          else if (cmd_r[BIT_FIELD] || tick_pend_r)
          begin
            meas_manual_r <= cmd_r[BIT_FIELD];
            next_meas_r <= 1'b1;
            if (auto_mag && (cmd_r[BIT_FIELD] || set_due))
            begin
              state_r <= ST_SET;
              timer_r <= TMR_W'(SR_PULSE_CYC - 1);
            end
            else
            begin
              state_r <= ST_MEAS;
              timer_r <= meas_load;
            end
          end
          else if (cmd_r[BIT_TEMP])
          begin
            state_r <= ST_TEMP;
            timer_r <= TMR_W'(TEMP_CYC - 1);
          end
        end
        ST_CALC:
        begin
          calc_cnt_r <= calc_cnt_r - 5'h01;
          if (calc_cnt_r == 5'h00)
          begin
            state_r <= ST_IDLE;
          end
        end
        ST_SET:
        begin
          if (!op_end)
          begin
            timer_r <= timer_r - 1'b1;
          end
          else if (next_meas_r)
          begin
            state_r <= ST_MEAS;
            timer_r <= meas_load;
          end
          else
          begin
            state_r <= ST_IDLE;
          end
        end
        ST_RST, ST_MEAS, ST_TEMP, ST_TEST:
        begin
          if (op_end)
          begin
            state_r <= ST_IDLE;
          end
          else
          begin
            timer_r <= timer_r - 1'b1;
          end
        end
      endcase
    end
  end

  assign set_coil_drive = (state_r == ST_SET);
  assign reset_coil_drive = (state_r == ST_RST);
  assign field_measuring = (state_r == ST_MEAS);
  assign temp_measuring = (state_r == ST_TEMP);
  assign selftest_running = (state_r == ST_TEST);

  // ************************************************
  // Sample period calculation
  // ************************************************
  // Restoring division, one quotient bit a cycle, trades speed for a tiny datapath.
  assign trial = {rem_r[9:0], dvd_r[26]};
  assign quo_nxt = {quo_r[25:0], (trial >= {1'b0, div_r})};

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      div_r <= 10'h000;
      dvd_r <= 27'h0000000;
      rem_r <= 11'h000;
      quo_r <= 27'h0000000;
      sample_period <= 27'h0000000;
      period_valid_r <= 1'b0;
    end
    else if (ce)
    begin
      if ((state_r == ST_IDLE) && cmd_r[BIT_CALC])
      begin
        div_r <= fast_rate ? FAST_RATE_HZ : {2'h0, rate_r};
        dvd_r <= CLK_HZ;
        rem_r <= 11'h000;
        quo_r <= 27'h0000000;
        period_valid_r <= 1'b0;
      end
      else if (state_r == ST_CALC)
      begin
        dvd_r <= {dvd_r[25:0], 1'b0};
        quo_r <= quo_nxt;
        rem_r <= quo_nxt[0] ? (trial - {1'b0, div_r}) : trial;
        if (calc_cnt_r == 5'h00)
        begin
          sample_period <= quo_nxt;
          period_valid_r <= (div_r != 10'h000);
        end
      end
    end
  end

  // ************************************************
  // Continuous mode and periodic set
  // ************************************************
  logic [26:0] per_cnt_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      continuous_active <= 1'b0;
      per_cnt_r <= 27'h0000000;
      tick_pend_r <= 1'b0;
    end
    else if (ce)
    begin
      continuous_active <= cont_run_enable && (rate_r != 8'h00) && period_valid_r;
      if (!continuous_active)
      begin
        per_cnt_r <= 27'h0000000;
        tick_pend_r <= 1'b0;
      end
      else if (per_cnt_r >= sample_period - 27'h0000001)
      begin
        per_cnt_r <= 27'h0000000;
        tick_pend_r <= 1'b1;
      end
      else
      begin
        per_cnt_r <= per_cnt_r + 27'h0000001;
        tick_pend_r <= tick_pend_r && !take_tick;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      smp_cnt_r <= 11'h000;
    end
    else if (ce)
    begin
      if (!continuous_active || !periodic_set_enable)
      begin
        smp_cnt_r <= 11'h000;
      end
      else if (take_tick)
      begin
        smp_cnt_r <= (smp_cnt_r >= 11'(PRD_SET_N[periodic_set_sel] - 1)) ? 11'h000
          : smp_cnt_r + 11'h001;
      end
    end
  end

  // ************************************************
  // Field result flag
  // ************************************************
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      field_result_ready <= 1'b0;
    end
    else if (ce)
    begin
      field_result_ready <= meas_done || (field_result_ready && !mag_data_read);
    end
  end

  // ************************************************
  // Checks
  // ************************************************
  logic [7:0] set_hi_r;
  logic [7:0] rst_hi_r;
  logic [TMR_W-1:0] meas_len_r;
  logic [TMR_W-1:0] meas_exp_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      set_hi_r <= 8'h00;
      rst_hi_r <= 8'h00;
      meas_len_r <= '0;
      meas_exp_r <= '0;
    end
    else if (ce)
    begin
      set_hi_r <= set_coil_drive ? set_hi_r + 8'h01 : 8'h00;
      rst_hi_r <= reset_coil_drive ? rst_hi_r + 8'h01 : 8'h00;
      meas_len_r <= field_measuring ? meas_len_r + 1'b1 : '0;
      if (!field_measuring)
      begin
        meas_exp_r <= meas_load + 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence calc_start;
    ce && (state_r == ST_IDLE) && cmd_r[BIT_CALC];
  endsequence

  sequence field_end;
    ce && (state_r == ST_MEAS) && op_end;
  endsequence

  set_width_a: assert property ($fell(set_coil_drive) |-> set_hi_r == 8'(SR_PULSE_CYC))
    else $error("Set pulse length is wrong.");

  rst_width_a: assert property ($fell(reset_coil_drive) |-> rst_hi_r == 8'(SR_PULSE_CYC))
    else $error("Reset pulse length is wrong.");

  motion_zero_a: assert property (command_bits[BIT_MOTION] == 1'b0)
    else $error("Reserved motion bit became set.");

  rate_store_a: assert property (wr_rate |=> sample_rate_code == $past(wr_bus.data))
    else $error("Rate code was not stored.");

  fast_divisor_a: assert property (calc_start |=> div_r == ($past(fast_rate) ? FAST_RATE_HZ
    : {2'h0, $past(rate_r)}))
    else $error("Divisor does not follow the fast rate condition.");

  field_clear_a: assert property (field_end and meas_manual_r
    && !(wr_ctrl && wr_bus.data[BIT_FIELD]) |=> !command_bits[BIT_FIELD])
    else $error("Field command bit did not clear at measurement end.");

  ready_hold_a: assert property (field_end |=> field_result_ready ##1
    (field_result_ready || $past(mag_data_read) || !$past(ce)))
    else $error("Field ready flag was not raised or dropped without a read.");

  meas_time_a: assert property ($fell(field_measuring) |-> meas_len_r == meas_exp_r)
    else $error("Measurement length does not match the filter setting.");

  cont_gate_a: assert property ($rose(continuous_active) |-> $past(cont_run_enable)
    && $past(period_valid_r) && $past(rate_r) != 8'h00)
    else $error("Continuous mode started without its conditions.");

  auto_gate_a: assert property ($rose(set_coil_drive) |-> $past(cmd_r[BIT_SET])
    || $past(auto_mag))
    else $error("Automatic set pulse without automatic set/reset enabled.");

endmodule : mcc_top

`default_nettype wire

//--- mcc_host_model.sv
/* Host model driving register writes over the serial link.
   Assumes an open-drain data line with a pull-up. */
`timescale 1ns/1ps
`default_nettype none

module mcc_host_model (
  output logic link_clk,
  output logic link_frame,
  output logic link_ccc,
  output logic link_sda_i,
  input wire logic link_sda_o,
  input wire logic link_sda_oe_n,
  output logic ack_bad
);
  logic drv;
  // Released by both sides the pull-up wins, so no stale value lingers.
  assign link_sda_i = drv & (link_sda_oe_n | link_sda_o);
  initial {link_clk, link_frame, link_ccc, drv, ack_bad} = 5'h02;
  // ****
  // Bit and frame tasks
  // ****
  task automatic pump;
    repeat (2)
    begin
      #7.5 link_clk = 1'b1;
      #7.5 link_clk = 1'b0;
    end
  endtask : pump
  task automatic bits(input logic [8:0] v);
    for (int i = 8; i >= 0; i--)
    begin
      drv = v[i];
      #7.5;
      if (i == 0 && link_sda_i !== 1'b0)
        ack_bad = 1'b1;
      link_clk = 1'b1;
      #7.5 link_clk = 1'b0;
    end
  endtask : bits
  // The clock stands still between frames.
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic c);
    link_ccc = c;
    link_frame = 1'b1;
    bits({a, 1'b1});
    bits({d, 1'b1});
    link_frame = 1'b0;
    link_ccc = 1'b0;
    #30;
  endtask : wr
endmodule : mcc_host_model

`default_nettype wire

//--- tb_top.sv
/* Self-checking bench for the measurement command block.
   Assumes the host model and shortened measurement counts. */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import mcc_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic cont = 1'b0;
  logic mrd = 1'b0;
  logic ce = 1'b1;
  logic hp = 1'b1;
  logic pse = 1'b0;
  logic [1:0] flt = 2'h3;
  logic [2:0] psel = 3'h0;
  logic lclk, frm, ccc, sdi, sdo, oen, ack_bad, setc, rstc, fm, tm, st, frdy, cact;
  logic [7:0] rate, cmd;
  logic [26:0] per;
  logic [5:0] mon;
  int err_count = 0;
  int check_count = 0;
  int run_len [6];
  assign mon = {cmd[7], st, tm, fm, rstc, setc};
  always #5 clk = ~clk;
  // Counts high cycles of each activity output off the edge, so a run that began
  // before its scenario looked is still measured in full.
  always @(negedge clk)
    for (int k = 0; k < 6; k++)
      run_len[k] <= mon[k] ? run_len[k] + 1 : 0;
  mcc_top #(.MEAS_CYC_BW2(100), .MEAS_CYC_BW3(60), .TEMP_CYC(50), .TEST_CYC(80)) i_mcc_top (
    .clk(clk), .resetn(resetn), .ce(ce),
    .link_clk(lclk), .link_frame(frm), .link_ccc(ccc), .link_sda_i(sdi), .link_sda_o(sdo),
    .link_sda_oe_n(oen), .cont_run_enable(cont), .high_power_sel(hp),
    .filter_length_sel(flt), .periodic_set_enable(pse), .periodic_set_sel(psel),
    .mag_data_read(mrd), .set_coil_drive(setc), .reset_coil_drive(rstc),
    .field_measuring(fm), .temp_measuring(tm), .selftest_running(st),
    .field_result_ready(frdy), .continuous_active(cact), .sample_rate_code(rate),
    .command_bits(cmd), .sample_period(per));
  mcc_host_model i_mcc_host_model (.link_clk(lclk), .link_frame(frm), .link_ccc(ccc),
    .link_sda_i(sdi), .link_sda_o(sdo), .link_sda_oe_n(oen), .ack_bad(ack_bad));
  // ****
  // Helpers
  // ****
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  task automatic wait_lvl(input int s, input logic v, output int n);
    n = 0;
    while (mon[s] !== v && n < 2000)
    begin
      @(posedge clk);
      #1 n++;
    end
    if (n == 2000)
    begin
      err_count++;
      tally_and_finish();
    end
  endtask : wait_lvl
  // Waits out one high run of an activity output, checks its length when len is above zero, then checks its command bit.
  task automatic meas(input int s, input int len, input int b);
    int n;
    wait_lvl(s, 1'b1, n);
    wait_lvl(s, 1'b0, n);
    if (len > 0)
      chk("active_cycles", len, run_len[s]);
    chk("self_clear", 0, cmd[b]);
  endtask : meas
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic c);
    i_mcc_host_model.wr(a, d, c);
    repeat (5) @(posedge clk);
    #1;
  endtask : wr
  // ****
  // Scenarios
  // ****
  task automatic s_zero_rate;
    chk("cmd_reset", 0, cmd);
    wr(8'h1b, 8'h80, 1'b0);
    meas(5, 0, 7);
    @(posedge clk) cont <= 1'b1;
    repeat (10) @(posedge clk);
    #1 chk("cont_zero_rate", 0, cact);
    @(posedge clk) cont <= 1'b0;
  endtask : s_zero_rate
  task automatic s_rate;
    wr(8'h1a, 8'hff, 1'b0);
    chk("rate_write", 8'hff, rate);
    wr(8'h9f, 8'h33, 1'b1);
    chk("rate_other_ccc", 8'hff, rate);
    wr(8'h8f, 8'h05, 1'b1);
    chk("rate_ccc", 8'h05, rate);
    wr(8'h30, 8'h01, 1'b0);
    chk("unmapped", 0, cmd);
  endtask : s_rate
  task automatic s_ops;
    wr(8'h1b, 8'h08, 1'b0);
    meas(0, 38, 3);
    wr(8'h1b, 8'h10, 1'b0);
    meas(1, 38, 4);
    wr(8'h1b, 8'h01, 1'b0);
    meas(2, 60, 0);
    chk("ready_set", 1, frdy);
    @(posedge clk) mrd <= 1'b1;
    @(posedge clk) mrd <= 1'b0;
    @(posedge clk);
    #1 chk("ready_clear", 0, frdy);
    @(posedge clk) flt <= 2'h2;
    wr(8'h1b, 8'h01, 1'b0);
    meas(2, 100, 0);
    @(posedge clk) flt <= 2'h3;
    wr(8'h1b, 8'h02, 1'b0);
    @(posedge clk) ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    #1 chk("held_by_ce", 1, cmd[1] & tm);
    meas(3, 70, 1);
    for (int a = 'h1e; a <= 'h20; a++)
      wr(8'(a), 8'h10, 1'b0);
    wr(8'h1b, 8'h40, 1'b0);
    meas(4, 80, 6);
    wr(8'h1b, 8'h21, 1'b0);
    meas(0, 38, 3);
    meas(2, 60, 0);
    chk("auto_kept", 1, cmd[5]);
  endtask : s_ops
  task automatic s_fast;
    @(posedge clk) hp <= 1'b0;
    wr(8'h1a, 8'hff, 1'b0);
    wr(8'h1b, 8'h80, 1'b0);
    meas(5, 0, 7);
    chk("period_low_power", 27'h5fbdc, per);
    @(posedge clk) hp <= 1'b1;
    wr(8'h1b, 8'h80, 1'b0);
    meas(5, 0, 7);
    chk("period_fast", 27'h186a0, per);
    @(posedge clk) cont <= 1'b1;
    repeat (5) @(posedge clk);
    #1 chk("cont_active", 1, cact);
    chk("acks", 0, ack_bad);
  endtask : s_fast
  initial
  begin
    i_mcc_host_model.pump();
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    s_zero_rate();
    s_rate();
    s_ops();
    s_fast();
    tally_and_finish();
  end
endmodule : tb_top

`default_nettype wire
